/* shared/adc_port_params.svh */
`ifndef ADC_PORT_PARAMS_SVH
`define ADC_PORT_PARAMS_SVH

// ****************************************************************
// widths and timing
// ****************************************************************
`define DATA_BITS        12
`define FIFO_WORDS       16
`define PIPE_DEPTH       5
`define STROBE_DELAY     2
`define CLK_PERIOD_NS    20
`define MIN_HALF_NS      19
`define MIN_HALF_CYCLES  ((`MIN_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MSB_FLIP         12'h800

`endif

/* shared/adc_port_pkg.sv */
package adc_port_pkg;

  // ****************************************************************
  // one conversion result
  // ****************************************************************
  typedef struct packed {
    logic        over_range;
    logic [11:0] code;
  } sample_word_t;

  typedef enum logic [1:0] {
    CODE_OFFSET_BINARY,
    CODE_TWOS_COMPLEMENT
  } code_format_t;

endpackage : adc_port_pkg

/* rtl/sample_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// small synchronous fifo, registered read data
// ****************************************************************
module sample_fifo
#(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("sample_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic             out_valid_ff;
  logic [AW:0]      mem_used;
  logic             mem_empty;
  logic             take;
  logic             push;

  assign mem_empty  = (wr_ptr_ff == rd_ptr_ff);
  assign mem_used   = wr_ptr_ff - rd_ptr_ff;
  // the output register counts toward the depth, so no more than DEPTH words are ever held
  assign in_ready_o = ({1'b0, mem_used} + {{(AW+1){1'b0}}, out_valid_ff}) < (AW+2)'(DEPTH);
  assign push       = in_valid_i && in_ready_o;
  // refill the output register whenever it is free or being drained
  assign take       = !mem_empty && (!out_valid_ff || out_ready_i);

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wr_ptr_ff <= '0;
    else if (push)
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_ptr_ff    <= '0;
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end
    else if (take)
    begin
      rd_ptr_ff    <= rd_ptr_ff + 1'b1;
      out_data_ff  <= mem_ff[rd_ptr_ff[AW-1:0]];
      out_valid_ff <= 1'b1;
    end
    else if (out_ready_i)
      out_valid_ff <= 1'b0;
  end

  assign out_data_o  = out_data_ff;
  assign out_valid_o = out_valid_ff;

endmodule : sample_fifo

`default_nettype wire

/* rtl/adc_parallel_output_port.sv */
// Overview of operation
// - code select high gives offset binary, low gives two's complement.
// - over-range flag high whenever the sample lies outside the convertible range.
// - output strobe is a delayed copy of the inverted sample strobe.
// - data change just after the output strobe falls, stable at its rise.
// - output disable high floats all data, flag and strobe outputs.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_params.svh"

module adc_parallel_output_port
  import adc_port_pkg::*;
#(
  parameter int PIPE_DEPTH   = `PIPE_DEPTH,
  parameter int FIFO_WORDS   = `FIFO_WORDS,
  parameter int STROBE_DELAY = `STROBE_DELAY
)
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  sample_strobe_in_i,
  input  wire logic                  output_code_select_i,
  input  wire logic                  output_disable_n_i,
  input  wire logic [`DATA_BITS-1:0] sample_code_i,
  input  wire logic                  sample_over_i,
  input  wire logic                  sample_under_i,
  input  wire logic                  sample_valid_i,
  output logic                       sample_ready_o,
  output logic      [`DATA_BITS-1:0] data_o,
  output logic      [`DATA_BITS-1:0] data_oe_o,
  output logic                       over_range_flag_o,
  output logic                       over_range_flag_oe_o,
  output logic                       data_strobe_out_o,
  output logic                       data_strobe_out_oe_o,
  output logic                       sample_lost_o
);

  if (PIPE_DEPTH < 1 || STROBE_DELAY < 1 || FIFO_WORDS < 2)
  begin : g_bad_param
    $error("adc_parallel_output_port: bad parameter");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [`DATA_BITS-1:0] format_code(input logic [`DATA_BITS-1:0] raw, input logic sel);
    // raw arrives offset binary; flipping the msb gives two's complement
    format_code = sel ? raw : (raw ^ `MSB_FLIP);
  endfunction : format_code

  // ****************************************************************
  // pin synchronisers, three stages, change once stages 2 and 3 agree
  // ****************************************************************
  logic [2:0] enc_sync_ff;
  logic [2:0] sel_sync_ff;
  logic [2:0] dis_sync_ff;
  logic       enc_ff;
  logic       sel_ff;
  logic       dis_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enc_sync_ff <= '0;
      sel_sync_ff <= '0;
      dis_sync_ff <= 3'h7;
    end
    else
    begin
      enc_sync_ff <= {enc_sync_ff[1:0], sample_strobe_in_i};
      sel_sync_ff <= {sel_sync_ff[1:0], output_code_select_i};
      dis_sync_ff <= {dis_sync_ff[1:0], output_disable_n_i};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enc_ff <= 1'b0;
      sel_ff <= 1'b0;
      dis_ff <= 1'b1;
    end
    else
    begin
      if (enc_sync_ff[2] == enc_sync_ff[1])
        enc_ff <= enc_sync_ff[2];
      if (sel_sync_ff[2] == sel_sync_ff[1])
        sel_ff <= sel_sync_ff[2];
      if (dis_sync_ff[2] == dis_sync_ff[1])
        dis_ff <= dis_sync_ff[2];
    end
  end

  logic enc_rise;
  logic enc_seen_ff;
  logic nxt_enc_seen;

  assign nxt_enc_seen = (enc_sync_ff[2] == enc_sync_ff[1]) ? enc_sync_ff[2] : enc_ff;
  assign enc_rise     = nxt_enc_seen && !enc_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      enc_seen_ff <= 1'b0;
    else
      enc_seen_ff <= enc_ff;
  end

  // ****************************************************************
  // sample intake through the fifo
  // ****************************************************************
  sample_word_t in_word;
  sample_word_t out_word;
  logic         fifo_valid;
  logic         fifo_take;

  assign in_word.over_range = sample_over_i || sample_under_i;
  assign in_word.code       = sample_code_i;

  sample_fifo #(
    .WIDTH ($bits(sample_word_t)),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   (in_word),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .out_data_o  (out_word),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_take)
  );

  // one word taken at each sample instant (encode rising edge)
  assign fifo_take = enc_rise;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sample_lost_o <= 1'b0;
    else
      sample_lost_o <= enc_rise && !fifo_valid;
  end

  // ****************************************************************
  // conversion pipeline, advances once per encode cycle
  // ****************************************************************
  sample_word_t pipe_ff [PIPE_DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < PIPE_DEPTH; i++)
        pipe_ff[i] <= '0;
    end
    else if (enc_rise)
    begin
      pipe_ff[0] <= fifo_valid ? out_word : pipe_ff[0];
      for (int i = 1; i < PIPE_DEPTH; i++)
        pipe_ff[i] <= pipe_ff[i-1];
    end
  end

  // ****************************************************************
  // output strobe and data
  // ****************************************************************
  // two taps more than the strobe: one each for the enc_ff and enc_seen lag; data_ff adds the cycle that trails the strobe fall
  localparam int FALL_TAPS = STROBE_DELAY + 2;

  logic [STROBE_DELAY-1:0] strobe_dly_ff;
  logic [FALL_TAPS-1:0]    fall_dly_ff;
  logic [`DATA_BITS-1:0]   data_ff;
  logic                    flag_ff;

  // strobe follows inverted encode after a fixed delay; data update rides a longer tap
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strobe_dly_ff <= '1;
      fall_dly_ff   <= '0;
    end
    else
    begin
      strobe_dly_ff <= STROBE_DELAY'({strobe_dly_ff, ~enc_seen_ff});
      fall_dly_ff   <= FALL_TAPS'({fall_dly_ff, enc_rise});
    end
  end

  // update one cycle after the strobe falls, well clear of the next rise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      data_ff <= '0;
      flag_ff <= 1'b0;
    end
    else if (fall_dly_ff[FALL_TAPS-1])
    begin
      data_ff <= format_code(pipe_ff[PIPE_DEPTH-1].code, sel_ff);
      flag_ff <= pipe_ff[PIPE_DEPTH-1].over_range;
    end
  end

  assign data_o               = data_ff;
  assign over_range_flag_o    = flag_ff;
  assign data_strobe_out_o    = strobe_dly_ff[STROBE_DELAY-1];
  // slow enable path is fine: disable is meant for long idle periods only
  assign data_oe_o            = {`DATA_BITS{!dis_ff}};
  assign over_range_flag_oe_o = !dis_ff;
  assign data_strobe_out_oe_o = !dis_ff;

endmodule : adc_parallel_output_port

`default_nettype wire

/* bench/adc_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module adc_port_asserts
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        sample_strobe_in_i,
  input wire logic        output_disable_n_i,
  input wire logic [11:0] data_o,
  input wire logic [11:0] data_oe_o,
  input wire logic        over_range_flag_o,
  input wire logic        over_range_flag_oe_o,
  input wire logic        data_strobe_out_o,
  input wire logic        data_strobe_out_oe_o,
  input wire logic        sample_lost_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // pin passes a 3-flop sync, so allow six samples
  sequence s_dis_held;
    output_disable_n_i [*6];
  endsequence
  sequence s_enc_rise;
    $rose(sample_strobe_in_i);
  endsequence
  property p_dis_float;
    s_dis_held |-> !over_range_flag_oe_o && !data_strobe_out_oe_o && data_oe_o == 12'h000;
  endproperty
  property p_oe_match;
    data_oe_o == {12{data_strobe_out_oe_o}} && over_range_flag_oe_o == data_strobe_out_oe_o;
  endproperty
  property p_strobe_fall;
    s_enc_rise |-> ##[3:8] $fell(data_strobe_out_o);
  endproperty
  property p_strobe_rise;
    $fell(sample_strobe_in_i) |-> ##[3:8] $rose(data_strobe_out_o);
  endproperty
  property p_upd_after_fall;
    ($changed(data_o) || $changed(over_range_flag_o)) |->
      !data_strobe_out_o && ($past(data_strobe_out_o) || $past(data_strobe_out_o, 2));
  endproperty
  property p_stable_at_rise;
    $rose(data_strobe_out_o) |-> $stable(data_o) && $stable(over_range_flag_o);
  endproperty
  property p_once_per_cycle;
    ($changed(data_o) || $changed(over_range_flag_o)) |=> ($stable(data_o) && $stable(over_range_flag_o)) [*6];
  endproperty
  property p_lost_pulse;
    $rose(sample_lost_o) |=> !sample_lost_o;
  endproperty
  a_dis_float: assert property (p_dis_float) else $error("driven while disabled");
  a_oe_match: assert property (p_oe_match) else $error("enables disagree");
  a_strobe_fall: assert property (p_strobe_fall) else $error("strobe did not fall");
  a_strobe_rise: assert property (p_strobe_rise) else $error("strobe did not rise");
  a_upd_after_fall: assert property (p_upd_after_fall) else $error("update off strobe fall");
  a_stable_at_rise: assert property (p_stable_at_rise) else $error("data moved at capture");
  a_once_per_cycle: assert property (p_once_per_cycle) else $error("two updates in a cycle");
  a_lost_pulse: assert property (p_lost_pulse) else $error("lost flag not a pulse");
endmodule : adc_port_asserts

bind adc_parallel_output_port adc_port_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .sample_strobe_in_i(sample_strobe_in_i), .output_disable_n_i(output_disable_n_i), .data_o(data_o),
  .data_oe_o(data_oe_o), .over_range_flag_o(over_range_flag_o), .over_range_flag_oe_o(over_range_flag_oe_o),
  .data_strobe_out_o(data_strobe_out_o), .data_strobe_out_oe_o(data_strobe_out_oe_o),
  .sample_lost_o(sample_lost_o));
`default_nettype wire

/* bench/capture_latch.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// downstream capture register
// ****
module capture_latch
  import adc_port_pkg::*;
(
  input  wire logic        strobe_i,
  input  wire logic [11:0] data_i,
  input  wire logic        flag_i,
  output var sample_word_t word_o,
  output logic      [15:0] count_o
);
  initial count_o = 16'h0000;
  // clocked by the delivered strobe, never a local encode copy
  always @(posedge strobe_i)
  begin
    word_o  <= {flag_i, data_i};
    count_o <= count_o + 16'h0001;
  end
endmodule : capture_latch
`default_nettype wire

/* bench/tb_adc_parallel_output_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_params.svh"
module tb_adc_parallel_output_port;
  import adc_port_pkg::*;
  localparam int P = 5;
  logic clk_i = 1'b0, rst_i = 1'b1, sample_strobe_in = 1'b0, sel = 1'b1, dis_n = 1'b0, valid = 1'b0, over = 1'b0, under = 1'b0;
  logic [11:0] code = 12'h000, data, oe;
  logic ready, flag, flag_oe, strobe, strobe_oe, lost;
  logic [15:0] cap_n;
  sample_word_t cap, exp_w;
  sample_word_t q[$];
  int bad_count = 0, total_checks = 0, skip = 0, lost_n = 0;
  // released lines show the inverse, so a float never passes as data
  wire logic [11:0] bus_d = data ^ ~oe;
  wire logic bus_f = flag ^ ~flag_oe;
  wire logic bus_s = strobe ^ ~strobe_oe;

  initial forever #10 clk_i = ~clk_i;

  adc_parallel_output_port #(.PIPE_DEPTH(P)) DUT (.clk_i(clk_i), .rst_i(rst_i), .sample_strobe_in_i(sample_strobe_in),
    .output_code_select_i(sel), .output_disable_n_i(dis_n), .sample_code_i(code), .sample_over_i(over),
    .sample_under_i(under), .sample_valid_i(valid), .sample_ready_o(ready), .data_o(data), .data_oe_o(oe),
    .over_range_flag_o(flag), .over_range_flag_oe_o(flag_oe), .data_strobe_out_o(strobe),
    .data_strobe_out_oe_o(strobe_oe), .sample_lost_o(lost));
  capture_latch u_rx (.strobe_i(bus_s), .data_i(bus_d), .flag_i(bus_f), .word_o(cap), .count_o(cap_n));

  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ****
  // capture monitor: a word reaches the pins on the P-th encode rise counting its own,
  // so the first P-1 captures of a burst are stale pipeline
  // ****
  always @(cap_n)
    if (q.size() > 0)
    begin
      if (skip > 0)
        skip--;
      else
      begin
        exp_w = q.pop_front();
        exp_w.code ^= sel ? 12'h000 : `MSB_FLIP;
        check(cap === exp_w, "captured word");
      end
    end

  always @(posedge clk_i)
    if (lost === 1'b1)
      lost_n++;

  task automatic push(input int n);
    logic [11:0] c;
    logic [1:0]  f;
    for (int i = 0; i < n; i++)
    begin
      c = 12'($urandom());
      f = 2'($urandom());
      code  <= c;
      {over, under} <= f;
      valid <= 1'b1;
      do @(posedge clk_i); while (ready !== 1'b1);
      q.push_back({f[0] | f[1], c});
    end
    valid <= 1'b0;
  endtask : push

  task automatic burst(input logic s, input int n, input logic extra);
    @(posedge clk_i);
    sel <= s;
    repeat (8) @(posedge clk_i);
    push(n);
    if (extra)
    begin
      @(negedge clk_i);
      check(ready === 1'b0, "fifo not full");
      @(posedge clk_i);
      code  <= 12'($urandom());
      valid <= 1'b1;
      repeat (2) @(posedge clk_i);
      valid <= 1'b0;
    end
    skip = P - 1;
    lost_n = 0;
    repeat (n + P)
    begin
      sample_strobe_in <= 1'b1;
      repeat (4) @(posedge clk_i);
      sample_strobe_in <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    repeat (20) @(posedge clk_i);
    check(q.size() == 0, "words missing");
    check(lost_n == P, "lost count");
  endtask : burst

  initial
  begin
    void'($urandom(32'h6528));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    check(oe === 12'hFFF && flag_oe === 1'b1 && strobe_oe === 1'b1, "outputs off");
    burst(1'b1, 16, 1'b1);
    burst(1'b0, 9, 1'b0);
    @(posedge clk_i);
    dis_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    check(oe === 12'h000 && flag_oe === 1'b0 && strobe_oe === 1'b0, "outputs driven");
    @(posedge clk_i);
    dis_n <= 1'b0;
    burst(1'b1, 5, 1'b0);
    stop_test();
  end

  initial
  begin
    #100000;
    bad_count++;
    stop_test();
  end
endmodule : tb_adc_parallel_output_port
`default_nettype wire
